// [rtl/uiw_pkg.sv]
// Purpose: Shared constants and types for the serial interrupt and wake block
// Assumes: 8-bit register port, 9-bit received words
// Notes: Offsets are register indices on the plain register port
package uiw_pkg;

	// Register offsets
	localparam logic [7:0] OFS_STATUS = 8'h00; // Status flags, read only
	localparam logic [7:0] OFS_CTRL2 = 8'h01; // Interrupt enables and modes
	localparam logic [7:0] OFS_IRQCTL = 8'h02; // Unit and global enables
	localparam logic [7:0] OFS_DATA = 8'h03; // Receive data, read pops
	localparam logic [7:0] OFS_CTRL1 = 8'h04; // Unit and receive path enables

	// Status bit positions
	localparam int ST_TX_EMPTY = 0; // Transmit data register empty
	localparam int ST_TX_IDLE = 1; // Transmitter idle
	localparam int ST_RX_AVAIL = 2; // Receive FIFO holds data
	localparam int ST_OVERRUN = 3; // Receive overrun seen
	localparam int ST_RX_BIT8 = 4; // Ninth bit of the FIFO head

	// Interrupt control bit positions
	localparam int IC_SERIAL_EN = 0; // Serial unit interrupt enable
	localparam int IC_GLOBAL_EN = 1; // Global interrupt enable

	// Control 1 bit positions
	localparam int C1_UNIT_EN = 0; // Serial unit enable
	localparam int C1_RX_EN = 1; // Receive path enable

	// Values after reset
	localparam logic [7:0] CTRL2_RST = 8'h00; // All sources masked
	localparam logic [1:0] IRQCTL_RST = 2'h0; // Interrupts off
	localparam logic [1:0] CTRL1_RST = 2'h0; // Unit off

	// Clock and settling time after a wake-up
	localparam int CLK_HZ = 50000000; // System clock rate
	localparam int SETTLE_CYCLES = 16; // Start-up cycles before normal run

	// Control 2 field layout
	typedef struct packed {
		logic spare; // Reads back as written, no effect
		logic parity_en_bit; // Parity checking enable
		logic ninth_bit_sel; // One selects nine-bit words
		logic pin_wake_en; // Pin wake-up enable
		logic addr_detect_en; // Address detect mode
		logic rx_irq_en; // Shared receive interrupt enable
		logic tx_idle_irq_en; // Transmitter idle interrupt enable
		logic tx_empty_irq_en; // Transmit empty interrupt enable
	} uiw_ctrl2_s;

	// Wake-up sequencer states
	typedef enum logic [1:0] {
		WK_IDLE = 2'b00,
		WK_SETTLE = 2'b01,
		WK_RELEASE = 2'b10
	} uiw_wake_e;

endpackage : uiw_pkg

// [rtl/uiw_top.sv]
// Purpose: Serial unit interrupt merge, address detect and pin wake-up
// Assumes: Clock stops while hs_clk_off is high; pin edge caught without it
// Notes: Baud, framing and FIFO datapath sit outside; they feed status in
//
// Overview of operation
// - Merge six sources into one interrupt
// - Request is an active-low pulse per event
// - Vector only with enables set, stack free
// - Flagged sources need their control enable bit
// - Transmit sources separate, receive sources share enable; address detect here is gated by addr_detect_en alone, not rx_irq_en
// - Address detect raises interrupt, no flag
// - Pin wake-up has no status flag
// - Flags read only, cleared by status-data sequence
// - Address mode: interrupt only on top bit high
// - Ninth bit select picks bit nine or eight
// - Top bit high words are addresses
// - Without address mode every avail raises interrupt
// - Clock off freezes unit, transmit pauses
// - Idle or sleep pauses reception
// - Registers unchanged across low power entry
// - Armed pin falling edge is a wake source
// - Pin data ignored while clock settles
// - Without enables wake only, no interrupt
// - Wake interrupt waits for settling to end
// - Avail flag set while FIFO holds data
// - Overrun raises shared receive interrupt
`timescale 1ns/1ps

module uiw_top #(
	parameter int SETTLE_CYCLES = uiw_pkg::SETTLE_CYCLES,
	parameter int CNT_W = 3
) (
	// Clock and reset
	input wire logic clk,
	input wire logic rst,
	// Register port
	input wire logic [7:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [7:0] reg_rdata,
	// Status from the serial datapath
	input wire logic tx_empty,
	input wire logic tx_idle,
	input wire logic [CNT_W-1:0] rx_fifo_count,
	input wire logic rx_trig_level,
	input wire logic rx_overrun,
	input wire logic rx_push,
	input wire logic [8:0] rx_word,
	input wire logic [8:0] rx_head,
	output logic rx_pop,
	// Control to the serial datapath
	output uiw_pkg::uiw_ctrl2_s ctrl2,
	output logic serial_unit_en,
	output logic rx_path_en,
	output logic freeze,
	output logic rx_ignore,
	// Power and pin
	input wire logic hs_clk_off,
	input wire logic low_power,
	input wire logic shared_rxtx_pin,
	output logic wake_req,
	// Processor interrupt logic
	input wire logic stack_full,
	output logic irq_n,
	output logic vector_req
);

	// Interrupt control register bits
	logic serial_irq_en;
	logic global_irq_en;
	// Sticky overrun flag
	logic overrun_flag;
	// Status read seen, arms the clear
	logic status_seen;
	// Registered level sources, previous cycle
	logic [2:0] src_prev;
	// Current enabled level sources
	logic [2:0] src_now;
	// Rising edges of level sources
	logic [2:0] src_rise;
	// Qualified address word pushed
	logic addr_evt;
	// Overrun event gated by shared enable
	logic ovr_evt;
	// Wake interrupt event after settling
	logic wake_evt;
	// Any new interrupt condition this cycle
	logic any_evt;
	// Request waiting for the processor
	logic pending;
	// Selected top bit of the pushed word
	logic top_bit;
	// Wake arm level, held while clock stops
	logic wake_arm;
	// Wake latch clear, from clock domain
	logic wake_clr;
	// Synchroniser stages for the latch
	logic wake_s1;
	logic wake_s2;
	// Wake sequencer
	uiw_pkg::uiw_wake_e wk_state;
	uiw_pkg::uiw_wake_e next_wk_state;
	logic [15:0] settle_cnt;
	// Read decode for the data and status registers
	logic data_rd;
	logic status_rd;

	// Register address decode
	assign data_rd = reg_rd && (reg_addr == uiw_pkg::OFS_DATA);
	assign status_rd = reg_rd && (reg_addr == uiw_pkg::OFS_STATUS);

	// Control writes; nothing else touches them
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			ctrl2 <= uiw_pkg::CTRL2_RST;
			serial_irq_en <= 1'b0;
			global_irq_en <= 1'b0;
			serial_unit_en <= 1'b0;
			rx_path_en <= 1'b0;
		end else if (reg_wr) begin
			// Low power entry leaves all of these alone
			if (reg_addr == uiw_pkg::OFS_CTRL2) begin
				ctrl2 <= reg_wdata;
			end
			// Interrupt enables
			if (reg_addr == uiw_pkg::OFS_IRQCTL) begin
				serial_irq_en <= reg_wdata[uiw_pkg::IC_SERIAL_EN];
				global_irq_en <= reg_wdata[uiw_pkg::IC_GLOBAL_EN];
			end
			// Unit and receive path enables
			if (reg_addr == uiw_pkg::OFS_CTRL1) begin
				serial_unit_en <= reg_wdata[uiw_pkg::C1_UNIT_EN];
				rx_path_en <= reg_wdata[uiw_pkg::C1_RX_EN];
			end
		end
	end

	// Status access then data read clears the error flag
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			status_seen <= 1'b0;
		end else if (status_rd) begin
			status_seen <= 1'b1;
		end else if (data_rd) begin
			status_seen <= 1'b0;
		end
	end

	// Sticky overrun; a new overrun beats the clear
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			overrun_flag <= 1'b0;
		end else if (rx_overrun) begin
			overrun_flag <= 1'b1;
		end else if (data_rd && status_seen) begin
			overrun_flag <= 1'b0;
		end
	end

	// Read data, one cycle after the strobe
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			reg_rdata <= 8'h00;
		end else if (reg_rd) begin
			unique case (reg_addr)
				// Flags are read only
				uiw_pkg::OFS_STATUS: begin
					reg_rdata <= 8'h00;
					reg_rdata[uiw_pkg::ST_TX_EMPTY] <= tx_empty;
					reg_rdata[uiw_pkg::ST_TX_IDLE] <= tx_idle;
					// Avail follows FIFO fill
					reg_rdata[uiw_pkg::ST_RX_AVAIL] <= (rx_fifo_count != '0);
					reg_rdata[uiw_pkg::ST_OVERRUN] <= overrun_flag;
					reg_rdata[uiw_pkg::ST_RX_BIT8] <= rx_head[8];
				end
				// Control readback
				uiw_pkg::OFS_CTRL2: begin
					reg_rdata <= ctrl2;
				end
				uiw_pkg::OFS_IRQCTL: begin
					reg_rdata <= {6'h00, global_irq_en, serial_irq_en};
				end
				uiw_pkg::OFS_CTRL1: begin
					reg_rdata <= {6'h00, rx_path_en, serial_unit_en};
				end
				// FIFO head, low eight bits
				uiw_pkg::OFS_DATA: begin
					reg_rdata <= rx_head[7:0];
				end
				// Unmapped reads as zero
				default: begin
					reg_rdata <= 8'h00;
				end
			endcase
		end else begin
			reg_rdata <= 8'h00;
		end
	end

	// Pop request to the FIFO on a data read
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			rx_pop <= 1'b0;
		end else begin
			rx_pop <= data_rd;
		end
	end

	// Top bit of the pushed word
	assign top_bit = ctrl2.ninth_bit_sel ? rx_word[8] : rx_word[7];

	// Enabled level sources
	always_comb begin
		src_now = 3'h0;
		// Own enable per transmit source
		src_now[0] = tx_empty && ctrl2.tx_empty_irq_en;
		src_now[1] = tx_idle && ctrl2.tx_idle_irq_en;
		// Trigger level shares the receive enable
		// Plain data avail only outside address mode
		src_now[2] = rx_trig_level && ctrl2.rx_irq_en && !ctrl2.addr_detect_en;
	end

	// Address words raise data avail
	assign addr_evt = rx_push && top_bit && ctrl2.addr_detect_en;
	// Overrun through the shared enable
	assign ovr_evt = rx_overrun && ctrl2.rx_irq_en;
	assign src_rise = src_now & ~src_prev;
	// Six sources merge here
	assign any_evt = (|src_rise) || addr_evt || ovr_evt || wake_evt;

	// Edge history of level sources
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			src_prev <= 3'h0;
		end else begin
			src_prev <= src_now;
		end
	end

	// One low cycle per new condition
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			irq_n <= 1'b1;
		end else begin
			irq_n <= !any_evt;
		end
	end

	// Pending request; a new event beats the vector clear
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			pending <= 1'b0;
		end else if (any_evt) begin
			pending <= 1'b1;
		end else if (vector_req) begin
			pending <= 1'b0;
		end
	end

	// Vector when both enables set and stack has room
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			vector_req <= 1'b0;
		end else begin
			vector_req <= pending && !vector_req && global_irq_en
				&& serial_irq_en && !stack_full;
		end
	end

	// Freeze the datapath when clock stops or in low power
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			freeze <= 1'b0;
		end else begin
			freeze <= hs_clk_off || low_power;
		end
	end

	// Arm level, frozen with the clock once it stops
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			wake_arm <= 1'b0;
		end else begin
			wake_arm <= hs_clk_off && ctrl2.pin_wake_en && serial_unit_en
				&& rx_path_en && ctrl2.rx_irq_en;
		end
	end

	// Edge latch on the pin itself, no system clock needed
	always_ff @(negedge shared_rxtx_pin or posedge rst or posedge wake_clr) begin
		if (rst) begin
			wake_req <= 1'b0;
		end else if (wake_clr) begin
			wake_req <= 1'b0;
		end else begin
			wake_req <= wake_arm || wake_req;
		end
	end

	// Two-stage synchroniser into the restarted clock
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			wake_s1 <= 1'b0;
			wake_s2 <= 1'b0;
		end else begin
			wake_s1 <= wake_req;
			wake_s2 <= wake_s1;
		end
	end

	// Wake sequencer next state
	always_comb begin
		next_wk_state = wk_state;
		unique case (wk_state)
			// Wait for a synchronised wake edge
			uiw_pkg::WK_IDLE: begin
				if (wake_s2) begin
					next_wk_state = uiw_pkg::WK_SETTLE;
				end
			end
			// Count start-up cycles
			uiw_pkg::WK_SETTLE: begin
				if (settle_cnt == 16'(SETTLE_CYCLES - 1)) begin
					next_wk_state = uiw_pkg::WK_RELEASE;
				end
			end
			// Wait for the latch clear to land
			uiw_pkg::WK_RELEASE: begin
				if (!wake_s2) begin
					next_wk_state = uiw_pkg::WK_IDLE;
				end
			end
			default: begin
				next_wk_state = uiw_pkg::WK_IDLE;
			end
		endcase
	end

	// Wake sequencer state and settle counter
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			wk_state <= uiw_pkg::WK_IDLE;
			settle_cnt <= 16'h0000;
		end else begin
			wk_state <= next_wk_state;
			if (wk_state == uiw_pkg::WK_SETTLE) begin
				settle_cnt <= settle_cnt + 16'h0001;
			end else begin
				settle_cnt <= 16'h0000;
			end
		end
	end

	// Interrupt only after settling and with enables
	assign wake_evt = (wk_state == uiw_pkg::WK_SETTLE)
		&& (next_wk_state == uiw_pkg::WK_RELEASE)
		&& global_irq_en && serial_irq_en;

	// Latch clear once settling ends
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			wake_clr <= 1'b0;
		end else begin
			wake_clr <= (next_wk_state == uiw_pkg::WK_RELEASE);
		end
	end

	// Ignore pin data while the clock settles
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			rx_ignore <= 1'b0;
		end else begin
			rx_ignore <= (next_wk_state == uiw_pkg::WK_SETTLE);
		end
	end

endmodule : uiw_top

// [test/uiw_assertions.sv]
// Purpose: Port checks for the serial interrupt and wake block
// Assumes: One clock domain, bench settle count of four
// Notes: Bound from the bench top file
`timescale 1ns/1ps
module uiw_assertions (
	// Clock and reset
	input logic clk,
	input logic rst,
	// Register port
	input logic [7:0] reg_addr,
	input logic reg_rd,
	input logic [7:0] reg_rdata,
	input logic rx_pop,
	// Sources, control and power
	input logic tx_empty,
	input logic rx_push,
	input logic [8:0] rx_word,
	input logic rx_overrun,
	input uiw_pkg::uiw_ctrl2_s ctrl2,
	input logic hs_clk_off,
	input logic low_power,
	input logic freeze,
	// Interrupt and wake
	input logic stack_full,
	input logic irq_n,
	input logic vector_req,
	input logic wake_req,
	input logic rx_ignore
);
	default clocking @(posedge clk); endclocking
	default disable iff (rst);
	logic top_bit; // Qualifying bit per word length
	assign top_bit = ctrl2.ninth_bit_sel ? rx_word[8] : rx_word[7];
	// Settle window held four cycles, then ends
	sequence settle_s;
		rx_ignore [*4] ##1 !rx_ignore;
	endsequence
	// Data register read taken
	sequence data_rd_s;
		reg_rd && reg_addr == uiw_pkg::OFS_DATA;
	endsequence
	tx_empty_a: assert property ($rose(tx_empty) && ctrl2.tx_empty_irq_en |=> !irq_n)
		else $error("tx empty event without request");
	addr_irq_a: assert property (rx_push && ctrl2.addr_detect_en && top_bit |=> !irq_n)
		else $error("address word without request");
	overrun_irq_a: assert property (rx_overrun && ctrl2.rx_irq_en |=> !irq_n)
		else $error("overrun without request");
	vector_gate_a: assert property (vector_req |-> !$past(stack_full))
		else $error("vector with stack full");
	rdata_idle_a: assert property (!$past(reg_rd) |-> reg_rdata == 8'h00)
		else $error("read data outside read slot");
	data_pop_a: assert property (data_rd_s |=> rx_pop)
		else $error("data read without pop");
	pop_cause_a: assert property (rx_pop |-> $past(reg_rd))
		else $error("pop without read");
	freeze_a: assert property (freeze == $past(hs_clk_off || low_power))
		else $error("freeze does not follow clock off or low power");
	settle_time_a: assert property ($rose(rx_ignore) |-> settle_s)
		else $error("settle window wrong");
	wake_end_a: assert property ($fell(rx_ignore) |-> ##[0:3] !wake_req)
		else $error("wake latch not cleared");
endmodule : uiw_assertions

// [test/uiw_remote.sv]
// Purpose: Remote serial device on the shared pin
// Assumes: Line idles high through a pull-up
// Notes: Sends only a start bit, enough to wake the unit
`timescale 1ns/1ps
module uiw_remote (
	// Shared pin
	output logic pin
);
	initial pin = 1'b1; // Idle line level
	// Start bit low for a chosen time, then idle
	task automatic start_bit(input int low_ns);
		#3 pin = 1'b0;
		#(low_ns) pin = 1'b1;
	endtask : start_bit
endmodule : uiw_remote

// [test/uiw_top_tb.sv]
// Purpose: Self-checking bench for the serial interrupt and wake block
// Assumes: Bench clock keeps running while the unit clock is off
// Notes: Settle count shortened to four cycles
`timescale 1ns/1ps
module uiw_top_tb;
	localparam int ST = 4; // Short settle count
	logic clk, rst, reg_wr, reg_rd, tx_empty, tx_idle, rx_trig_level, rx_overrun, rx_push;
	logic hs_clk_off, low_power, stack_full, rx_pop, rx_ignore, wake_req, irq_n, vector_req;
	logic pin, popped;
	logic freeze, serial_unit_en, rx_path_en;
	uiw_pkg::uiw_ctrl2_s ctrl2;
	logic [7:0] reg_addr, reg_wdata, reg_rdata;
	logic [2:0] rx_fifo_count;
	logic [8:0] rx_word, rx_head;
	int error_cnt, comparisons;
	// 50 MHz clock
	initial begin
		clk = 1'b0;
		forever #10 clk = ~clk;
	end
	uiw_top #(.SETTLE_CYCLES(ST)) i_dut (
		.clk(clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
		.reg_rd(reg_rd), .reg_rdata(reg_rdata), .tx_empty(tx_empty), .tx_idle(tx_idle),
		.rx_fifo_count(rx_fifo_count), .rx_trig_level(rx_trig_level),
		.rx_overrun(rx_overrun), .rx_push(rx_push), .rx_word(rx_word), .rx_head(rx_head),
		.rx_pop(rx_pop), .ctrl2(ctrl2), .serial_unit_en(serial_unit_en),
		.rx_path_en(rx_path_en), .freeze(freeze),
		.rx_ignore(rx_ignore), .hs_clk_off(hs_clk_off), .low_power(low_power),
		.shared_rxtx_pin(pin), .wake_req(wake_req), .stack_full(stack_full), .irq_n(irq_n),
		.vector_req(vector_req));
	uiw_remote i_rem (.pin(pin));
	// Count and report one comparison
	task automatic ck(input logic ok, input string m);
		comparisons++;
		if (ok !== 1'b1) begin
			error_cnt++;
			$display("CHECK FAILED %0t %s", $time, m);
		end
	endtask : ck
	// Register write, one idle cycle after
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		{reg_addr, reg_wdata, reg_wr} <= {a, d, 1'b1};
		@(posedge clk);
		reg_wr <= 1'b0;
		@(posedge clk);
	endtask : wr
	// Register read, data checked in the slot after the strobe
	task automatic rd(input logic [7:0] a, input logic [7:0] e, input string m);
		{reg_addr, reg_rd} <= {a, 1'b1};
		@(posedge clk);
		reg_rd <= 1'b0;
		#1 ck(reg_rdata === e, m);
		popped = rx_pop;
		@(posedge clk);
	endtask : rd
	// Pulses drop after one cycle; request then vector checked
	task automatic ev_chk(input logic ei, input logic ev, input string m);
		@(posedge clk);
		{rx_push, rx_overrun} <= 2'b00;
		#1 ck(irq_n === !ei, m);
		@(posedge clk);
		#1 ck(vector_req === ev, {m, " vector"});
		@(posedge clk);
	endtask : ev_chk
	task automatic t_regs;
		rd(uiw_pkg::OFS_CTRL2, uiw_pkg::CTRL2_RST, "ctrl2 reset");
		rd(uiw_pkg::OFS_IRQCTL, {6'h00, uiw_pkg::IRQCTL_RST}, "irqctl reset");
		rd(uiw_pkg::OFS_CTRL1, {6'h00, uiw_pkg::CTRL1_RST}, "ctrl1 reset");
		wr(uiw_pkg::OFS_CTRL2, 8'ha5);
		rd(uiw_pkg::OFS_CTRL2, 8'ha5, "ctrl2 rw");
		ck(ctrl2 === 8'ha5, "ctrl2 out");
		wr(uiw_pkg::OFS_STATUS, 8'hff);
		rd(uiw_pkg::OFS_STATUS, 8'h00, "status write");
		rd(8'h3c, 8'h00, "unmapped");
		$display("t_regs done");
	endtask : t_regs
	task automatic t_tx;
		wr(uiw_pkg::OFS_IRQCTL, 8'h03);
		wr(uiw_pkg::OFS_CTRL2, 8'h01);
		tx_idle <= 1'b1; // Masked source
		ev_chk(1'b0, 1'b0, "tx idle masked");
		tx_empty <= 1'b1;
		ev_chk(1'b1, 1'b1, "tx empty");
		{tx_idle, stack_full} <= 2'b01;
		wr(uiw_pkg::OFS_CTRL2, 8'h02);
		tx_idle <= 1'b1;
		ev_chk(1'b1, 1'b0, "stack full");
		stack_full <= 1'b0;
		@(posedge clk);
		#1 ck(vector_req === 1'b1, "pending held");
		@(posedge clk);
		{tx_empty, tx_idle} <= 2'b00;
		$display("t_tx done");
	endtask : t_tx
	task automatic t_addr;
		logic a, n, t;
		for (int i = 0; i < 8; i++) begin
			{a, n, t} = i[2:0];
			wr(uiw_pkg::OFS_CTRL2, {2'b00, n, 1'b0, a, 3'b100});
			{rx_push, rx_trig_level} <= 2'b11;
			rx_word <= n ? {t, !t, 7'h00} : {!t, t, 7'h00};
			ev_chk(!a || t, !a || t, "address mode");
			rx_trig_level <= 1'b0;
		end
		$display("t_addr done");
	endtask : t_addr
	task automatic t_ovr;
		// Data read first drops any earlier status access
		rd(uiw_pkg::OFS_DATA, 8'h00, "data empty");
		{rx_fifo_count, rx_head, rx_overrun} <= {3'h1, 9'h1a5, 1'b1};
		ev_chk(1'b1, 1'b1, "overrun");
		rd(uiw_pkg::OFS_DATA, 8'ha5, "data only");
		rd(uiw_pkg::OFS_STATUS, 8'h1c, "status flags");
		rd(uiw_pkg::OFS_DATA, 8'ha5, "data");
		ck(popped === 1'b1, "pop");
		rd(uiw_pkg::OFS_STATUS, 8'h14, "overrun clear");
		wr(uiw_pkg::OFS_CTRL2, 8'h00);
		rx_overrun <= 1'b1;
		ev_chk(1'b0, 1'b0, "overrun masked");
		$display("t_ovr done");
	endtask : t_ovr
	task automatic t_wake(input logic en, input logic arm, input string m);
		int n;
		logic ig;
		{n, ig} = 0;
		wr(uiw_pkg::OFS_IRQCTL, {6'h00, en, en});
		wr(uiw_pkg::OFS_CTRL1, 8'h03);
		wr(uiw_pkg::OFS_CTRL2, {3'b000, arm, 4'b0100});
		{hs_clk_off, low_power} <= 2'b11;
		repeat (2) @(posedge clk);
		i_rem.start_bit(5);
		ck(wake_req === arm, m);
		ck(freeze === 1'b1, {m, " freeze"});
		ck({rx_path_en, serial_unit_en} === 2'b11, {m, " unit on"});
		ck(ctrl2 === {3'b000, arm, 4'b0100}, {m, " ctrl2"});
		@(posedge clk);
		{hs_clk_off, low_power} <= 2'b00;
		while (n < 40) begin
			@(posedge clk);
			// Look after the edge, once outputs have settled
			#1 ig = ig | rx_ignore;
			if (irq_n === 1'b0)
				break;
			n++;
		end
		ck(ig === arm, {m, " settle"});
		ck((n < 40) === (en && arm), {m, " request"});
		ck(!(en && arm) || n >= ST, {m, " early"});
		ck(freeze === 1'b0, {m, " thaw"});
		@(posedge clk);
		rd(uiw_pkg::OFS_CTRL2, {3'b000, arm, 4'b0100}, {m, " kept"});
		$display("t_wake done");
	endtask : t_wake
	// Counts, verdict, end of run
	task automatic end_sim;
		$display("comparisons %0d errors %0d", comparisons, error_cnt);
		if (error_cnt == 0 && comparisons > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask : end_sim
	// Watchdog
	initial begin
		#100us;
		error_cnt++;
		end_sim();
	end
	// Main sequence
	initial begin
		{reg_wr, reg_rd, tx_empty, tx_idle, rx_trig_level, rx_overrun, rx_push} = 7'h00;
		{hs_clk_off, low_power, stack_full, reg_addr, reg_wdata} = 19'h00000;
		{rx_fifo_count, rx_word, rx_head} = 21'h000000;
		{error_cnt, comparisons} = 0;
		rst = 1'b1;
		repeat (16) @(posedge clk);
		rst <= 1'b0;
		@(posedge clk);
		t_regs();
		t_tx();
		t_addr();
		t_ovr();
		t_wake(1'b1, 1'b1, "wake");
		t_wake(1'b0, 1'b1, "wake masked");
		t_wake(1'b1, 1'b0, "unarmed");
		end_sim();
	end
endmodule : uiw_top_tb
bind uiw_top uiw_assertions u_chk (.clk(clk), .rst(rst), .reg_addr(reg_addr), .reg_rd(reg_rd),
	.reg_rdata(reg_rdata), .rx_pop(rx_pop), .tx_empty(tx_empty), .rx_push(rx_push),
	.rx_word(rx_word), .rx_overrun(rx_overrun), .ctrl2(ctrl2), .hs_clk_off(hs_clk_off),
	.low_power(low_power), .freeze(freeze), .stack_full(stack_full), .irq_n(irq_n),
	.vector_req(vector_req), .wake_req(wake_req), .rx_ignore(rx_ignore));
